/* File: design/mct_pkg.sv */
// Shared constants and types for the match/capture timer set
package mct_pkg;
	localparam int          MCT_NUM_TIMERS  = 3;
	localparam int          MCT_NUM_MATCH   = 3;
	localparam int          MCT_NUM_CAP_TMR = 2;
	localparam int          MCT_CAP_PER_TMR = 2;
	localparam int          MCT_CNT_W       = 32;
	localparam logic [31:0] MCT_CNT_RESET   = 32'h0000_0000;
	localparam logic [31:0] MCT_CNT_STEP    = 32'h0000_0001;
	localparam int          MCT_DIV_W       = 8;
	localparam logic [7:0]  MCT_DIV_ZERO    = 8'h00;
	localparam logic [7:0]  MCT_DIV_ONE     = 8'h01;
	localparam int          MCT_TICK_DIV    = 1;
	localparam int          MCT_CAP_LAT     = 2;

	// Action taken when a match value is reached
	typedef struct packed {
		logic irq_en;
		logic reset_cnt;
		logic stop_cnt;
	} mct_match_cfg_t;

	// Per capture input setup
	typedef struct packed {
		logic enable;
		logic on_rise;
		logic on_fall;
		logic irq_en;
	} mct_cap_cfg_t;
endpackage

/* File: design/mct_timer_set.sv */
// Three 32-bit timers with match units and capture inputs
//
// Summary of operation
// - Three independent 32-bit counters, each count readable at an output.
// - Count advances by one per counting tick while its timer runs.
// - Three match values per timer; equality raises interrupt, reset or stop.
// - Only timers zero and one have capture inputs, two each.
// - A qualifying edge on an enabled capture input latches the count.
// - Capture raises the timer interrupt only if its interrupt is enabled.
// - Counting tick is the system clock, optionally divided by a prescaler.
`timescale 1ns/10ps
`default_nettype none

module mct_timer_set
	import mct_pkg::*;
#(
	parameter int NT       = MCT_NUM_TIMERS,
	parameter int NM       = MCT_NUM_MATCH,
	parameter int NCT      = MCT_NUM_CAP_TMR,
	parameter int NC       = MCT_CAP_PER_TMR,
	parameter int CW       = MCT_CNT_W,
	parameter int TICK_DIV = MCT_TICK_DIV
) (
	// Clock and reset
	input  wire logic                            sys_clk_i,
	input  wire logic                            rst_n_i,
	// Timer control
	input  wire logic [NT-1:0]                   run_i,
	input  wire logic [NT-1:0]                   clear_i,
	// Match setup
	input  wire logic [NT-1:0][NM-1:0][CW-1:0]   match_val_i,
	input  wire mct_match_cfg_t [NT-1:0][NM-1:0] match_cfg_i,
	// Capture inputs and setup
	input  wire logic [NCT-1:0][NC-1:0]          cap_in_i,
	input  wire mct_cap_cfg_t [NCT-1:0][NC-1:0]  cap_cfg_i,
	// Counts and captured values
	output logic [NT-1:0][CW-1:0]                count_o,
	output logic [NCT-1:0][NC-1:0][CW-1:0]       cap_val_o,
	// Event pulses and stop status
	output logic [NT-1:0][NM-1:0]                match_o,
	output logic [NCT-1:0][NC-1:0]               cap_evt_o,
	output logic [NT-1:0]                        irq_o,
	output logic [NT-1:0]                        stopped_o
);

	logic [MCT_DIV_W-1:0] div_reg;
	logic                 tick;
	logic [NT-1:0]        counting;
	logic [NT-1:0][NM-1:0] hit;
	logic [NT-1:0]        cap_irq;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg <= MCT_DIV_ZERO;
		end else if (div_reg == MCT_DIV_W'(TICK_DIV - 1)) begin
			div_reg <= MCT_DIV_ZERO;
		end else begin
			div_reg <= div_reg + MCT_DIV_ONE;
		end
	end
	assign tick = (div_reg == MCT_DIV_ZERO);

	genvar t, m, c;
	generate
		for (t = 0; t < NT; t++) begin : g_tmr
			logic          any_reset;
			logic          any_stop;
			logic [NM-1:0] irq_hit;

			assign counting[t] = run_i[t] & ~stopped_o[t] & tick;

			for (m = 0; m < NM; m++) begin : g_match
				assign hit[t][m] = counting[t] &
					(count_o[t] == match_val_i[t][m]);
				assign irq_hit[m] = hit[t][m] & match_cfg_i[t][m].irq_en;
			end

			// Reduce the match actions
			always_comb begin
				any_reset = 1'b0;
				any_stop  = 1'b0;
				for (int k = 0; k < NM; k++) begin
					any_reset |= hit[t][k] & match_cfg_i[t][k].reset_cnt;
					any_stop  |= hit[t][k] & match_cfg_i[t][k].stop_cnt;
				end
			end

			// count register, match reset wins over increment
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					count_o[t] <= MCT_CNT_RESET;
				end else if (clear_i[t] | any_reset) begin
					count_o[t] <= MCT_CNT_RESET;
				end else if (counting[t]) begin
					count_o[t] <= count_o[t] + MCT_CNT_STEP;
				end
			end

			// stop on match; dropping run releases it
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stopped_o[t] <= 1'b0;
				end else if (any_stop) begin
					stopped_o[t] <= 1'b1;
				end else if (!run_i[t]) begin
					stopped_o[t] <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					match_o[t] <= '0;
					irq_o[t]   <= 1'b0;
				end else begin
					match_o[t] <= hit[t];
					irq_o[t]   <= (|irq_hit) | cap_irq[t];
				end
			end
		end

		// capture hardware only on the first timers
		for (t = 0; t < NT; t++) begin : g_capirq
			if (t < NCT) begin : g_has
				logic [NC-1:0] edge_irq;
				for (c = 0; c < NC; c++) begin : g_cap
					logic sync1_reg;
					logic sync2_reg;
					logic prev_reg;
					logic fire;

					always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
						if (!rst_n_i) begin
							sync1_reg <= 1'b0;
							sync2_reg <= 1'b0;
							prev_reg  <= 1'b0;
						end else begin
							sync1_reg <= cap_in_i[t][c];
							sync2_reg <= sync1_reg;
							prev_reg  <= sync2_reg;
						end
					end

					assign fire = cap_cfg_i[t][c].enable &
						((cap_cfg_i[t][c].on_rise & sync2_reg & ~prev_reg) |
						 (cap_cfg_i[t][c].on_fall & ~sync2_reg & prev_reg));

					assign edge_irq[c] = fire & cap_cfg_i[t][c].irq_en;

					always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
						if (!rst_n_i) begin
							cap_val_o[t][c] <= MCT_CNT_RESET;
							cap_evt_o[t][c] <= 1'b0;
						end else begin
							cap_evt_o[t][c] <= fire;
							if (fire) begin
								cap_val_o[t][c] <= count_o[t];
							end
						end
					end
				end
				assign cap_irq[t] = |edge_irq;
			end else begin : g_none
				// Third timer has no capture source
				assign cap_irq[t] = 1'b0;
			end
		end
	endgenerate

	// Capture pipeline depth, kept local so the delay is a plain constant
	localparam int CAP_LAT = MCT_CAP_LAT;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_count_step: assert property (
		counting[0] && !clear_i[0] && !(|hit[0]) |=>
			count_o[0] == $past(count_o[0]) + MCT_CNT_STEP
	) else $error("timer 0 did not advance by one");

	chk_count_hold: assert property (
		!run_i[1] && !clear_i[1] |=> $stable(count_o[1])
	) else $error("stopped timer 1 changed count");

	chk_match_pulse: assert property (
		run_i[0] && !stopped_o[0] && tick &&
			count_o[0] == match_val_i[0][1] |=> match_o[0][1]
	) else $error("match 1 of timer 0 not flagged");

	chk_match_reset: assert property (
		hit[2][0] && match_cfg_i[2][0].reset_cnt |=>
			count_o[2] == MCT_CNT_RESET
	) else $error("match reset did not clear timer 2");

	chk_match_irq: assert property (
		match_o[0][0] && $past(match_cfg_i[0][0].irq_en) |-> irq_o[0]
	) else $error("enabled match gave no interrupt");

	chk_cap_latch: assert property (
		cap_evt_o[1][0] |-> cap_val_o[1][0] == $past(count_o[1])
	) else $error("capture did not latch running count");

	chk_cap_irq: assert property (
		cap_evt_o[0][1] && $past(cap_cfg_i[0][1].irq_en) |-> irq_o[0]
	) else $error("enabled capture gave no interrupt");

	chk_cap_quiet: assert property (
		!(|hit[0]) && !(|(g_capirq[0].g_has.edge_irq)) |=> !irq_o[0]
	) else $error("interrupt with no enabled cause");

	chk_cap_latency: assert property (
		$rose(cap_in_i[0][0]) && cap_cfg_i[0][0].enable &&
			cap_cfg_i[0][0].on_rise ##CAP_LAT
			(cap_cfg_i[0][0].enable && cap_cfg_i[0][0].on_rise &&
			 cap_in_i[0][0]) |=> cap_evt_o[0][0]
	) else $error("rising capture edge missed");

	chk_tick_rate: assert property (
		!tick && !clear_i[0] && !(|hit[0]) |=> $stable(count_o[0])
	) else $error("count moved without a tick");

	cov_match_stop: cover property (hit[0][2] && match_cfg_i[0][2].stop_cnt);
	cov_cap_fall: cover property (cap_evt_o[1][1] && cap_cfg_i[1][1].on_fall);
	cov_irq_both: cover property (irq_o[0] && match_o[0] != '0);

endmodule

`default_nettype wire

/* File: verification/mct_cap_src.sv */
// Model of the external signals that feed the capture inputs
`timescale 1ns/10ps
`default_nettype none

module mct_cap_src (
	// Clock and requested pin levels
	input  wire logic       sys_clk_i,
	input  wire logic [3:0] level_i,
	// Pins toward the timers
	output logic [3:0]      cap_in_o
);
	// Pins move shortly after the edge, so each level lasts whole cycles
	initial begin
		cap_in_o = 4'h0;
	end
	always @(posedge sys_clk_i) begin
		cap_in_o <= #1 level_i;
	end
endmodule

`default_nettype wire

/* File: verification/tb_match_capture_timer_set.sv */
// Self-checking bench for the match/capture timer set
`timescale 1ns/10ps
`default_nettype none

module tb_match_capture_timer_set;
	import mct_pkg::*;
	logic                      sys_clk_i;
	logic                      rst_n_i;
	logic [2:0]                run;
	logic [2:0]                clr;
	logic [2:0][2:0][31:0]     mval;
	mct_match_cfg_t [2:0][2:0] mcfg;
	mct_cap_cfg_t [1:0][1:0]   ccfg;
	logic [3:0]                lvl;
	logic [3:0]                cap_in;
	logic [2:0][31:0]          count;
	logic [2:0][31:0]          count_div;
	logic [1:0][1:0][31:0]     cap_val;
	logic [2:0][2:0]           match;
	logic [1:0][1:0]           cap_evt;
	logic [2:0]                irq;
	logic [2:0]                stopped;
	int                        n_fail;
	int                        n_compared;
	int                        cyc;
	localparam int             DIV = 3;

	mct_timer_set dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(run),
		.clear_i(clr), .match_val_i(mval), .match_cfg_i(mcfg), .cap_in_i(cap_in),
		.cap_cfg_i(ccfg), .count_o(count), .cap_val_o(cap_val), .match_o(match),
		.cap_evt_o(cap_evt), .irq_o(irq), .stopped_o(stopped));
	mct_cap_src src (.sys_clk_i(sys_clk_i), .level_i(lvl), .cap_in_o(cap_in));
	// Second copy with a slow counting tick for the prescaler
	mct_timer_set #(.TICK_DIV(DIV)) dut_div (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .run_i(run), .clear_i(clr), .match_val_i(mval),
		.match_cfg_i(mcfg), .cap_in_i(cap_in), .cap_cfg_i(ccfg),
		.count_o(count_div), .cap_val_o(), .match_o(), .cap_evt_o(),
		.irq_o(), .stopped_o());

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Counts per tick, holds when halted
	task automatic t_count();
		clr = 3'h7;
		tick(1);
		clr = 3'h0;
		run = 3'h1;
		tick(9);
		chk("count run", count[0], 32'h9);
		chk("count divided", count_div[0], 32'(9 / DIV));
		run = 3'h0;
		tick(4);
		chk("count held", count[0], 32'h9);
		chk("divided held", count_div[0], 32'(9 / DIV));
	endtask

	// Run timers zero and one for six ticks, then freeze them for captures
	task automatic t_freeze();
		clr = 3'h7;
		tick(1);
		clr = 3'h0;
		run = 3'h3;
		tick(6);
		run = 3'h0;
		chk("count frozen", count[1], 32'h6);
	endtask

	// Match hit one cycle after the count reaches the value
	task automatic t_match(input int t, input mct_match_cfg_t c,
		input logic [31:0] v, e);
		clr = 3'h7;
		mval[t][0] = v;
		mcfg[t][0] = c;
		tick(1);
		clr = 3'h0;
		run[t] = 1'b1;
		tick(v + 1);
		chk("match pulse", match[t][0], 32'h1);
		chk("match irq", irq[t], c.irq_en);
		chk("count at hit", count[t], e);
		tick(3);
		chk("stopped", stopped[t], c.stop_cnt);
		run = 3'h0;
		mcfg[t][0] = 3'h0;
		tick(1);
	endtask

	// Pin moves one edge after the level, result two edges after sampling
	task automatic t_cap(input int i, input mct_cap_cfg_t c, input logic up, ex,
		input logic [31:0] v);
		ccfg[i/2][i%2] = c;
		lvl[i] = up;
		tick(4);
		chk("cap event", cap_evt[i/2][i%2], ex);
		chk("cap irq", irq[i/2], ex & c.irq_en);
		chk("cap value", cap_val[i/2][i%2], v);
		tick(1);
		chk("cap pulse end", cap_evt[i/2][i%2], 32'h0);
	endtask

	// Hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		{rst_n_i, run, clr, mval, mcfg, ccfg, lvl} = '0;
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		tick(16);
		rst_n_i = 1'b1;
		t_count();
		t_match(1, 3'h6, 32'h5, 32'h0);
		t_match(2, 3'h1, 32'h4, 32'h5);
		t_match(2, 3'h2, 32'h3, 32'h0);
		t_match(0, 3'h4, 32'h7, 32'h8);
		t_freeze();
		// Edge select, enable and interrupt enable combinations
		t_cap(0, 4'hD, 1'b1, 1'b1, 32'h6);
		t_cap(0, 4'hD, 1'b0, 1'b0, 32'h6);
		t_cap(1, 4'hB, 1'b1, 1'b0, 32'h0);
		t_cap(1, 4'hB, 1'b0, 1'b1, 32'h6);
		t_cap(2, 4'h7, 1'b1, 1'b0, 32'h0);
		t_cap(3, 4'hF, 1'b1, 1'b1, 32'h6);
		t_cap(3, 4'hF, 1'b0, 1'b1, 32'h6);
		t_cap(2, 4'hE, 1'b0, 1'b1, 32'h6);
		summarize();
	end
endmodule

`default_nettype wire
